/* File: sld_defs.vh */
// sld_defs.vh: constants for the serial-in latched 32-bit driver block
// assumes: included by sld_driver.v; definitions only
//
// Summary of operation
// [R1] each rising shift-clock edge that the fifo accepts captures the serial input into the first stage
// [R2] each rising shift-clock edge that the fifo accepts moves every stage one place toward the serial output
// [R3] shift register, latches and outputs are each 32 positions wide
// [R4] the last shift stage is driven on the serial output for cascading
// [R5] while strobe is high every latch follows its shift stage
// [R6] host keeps blanking high during shifting when strobe is tied high
// [R7] while blanking is high all outputs are forced low, sinks on
// [R8] blanking never changes latch contents, only the output stage
// [R9] while blanking is low each output follows its own latch
// [R10] while strobe is low latches and outputs ignore shifting activity
`ifndef SLD_DEFS_VH
`define SLD_DEFS_VH

`define SLD_WIDTH        32
`define SLD_FIFO_WIDTH   1
`define SLD_FIFO_DEPTH   8
`define SLD_FIFO_AW      3
`define SLD_SREG_RESET   32'h0000_0000
`define SLD_LATCH_RESET  32'h0000_0000
`define SLD_SERIAL_MSB   31

`endif

/* File: sld_driver.v */
// sld_driver.v: serial-in, latched, blankable 32-bit driver with an 8-entry bit fifo
// assumes: all host pins are asynchronous to clk and are synchronised here;
// shift_hold comes from logic on clk; host shift clock is well below clk/4
`timescale 1ns/1ps
`default_nettype none
`include "sld_defs.vh"

module sld_fifo #(
  parameter WIDTH = `SLD_FIFO_WIDTH,
  parameter DEPTH = `SLD_FIFO_DEPTH,
  parameter AW    = `SLD_FIFO_AW
) (
  // clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             clk_en,
  // fill side
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output reg              in_ready,
  // drain side
  output reg              out_valid,
  output wire [WIDTH-1:0] out_data,
  input  wire             out_ready
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_q;
  reg  [AW-1:0]    rd_ptr_q;
  reg  [AW:0]      count_q;
  wire             push;
  wire             pop;
  wire [AW:0]      count_d;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem[rd_ptr_q];
  assign count_d  = push & ~pop ? count_q + 1'b1 :
                    pop & ~push ? count_q - 1'b1 : count_q;

  always @(posedge clk) begin
    if (clk_en && push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_q  <= {AW{1'b0}};
      rd_ptr_q  <= {AW{1'b0}};
      count_q   <= {(AW+1){1'b0}};
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else if (clk_en) begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      end
      count_q   <= count_d;
      in_ready  <= (count_d != DEPTH);
      out_valid <= (count_d != {(AW+1){1'b0}});
    end
  end
endmodule // sld_fifo

module sld_driver #(
  parameter WIDTH = `SLD_WIDTH
) (
  // clock, reset and enable
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             clk_en,
  // host pins
  input  wire             shift_clk,
  input  wire             serial_in,
  input  wire             strobe,
  input  wire             blanking,
  // local flow control
  input  wire             shift_hold,
  output reg              fifo_ready_q,
  // cascade and drive outputs
  output reg              serial_out_q,
  output reg  [WIDTH-1:0] drive_high_q,
  output reg  [WIDTH-1:0] sink_on_q
);
  reg  [1:0]       sclk_sync_q;
  reg  [1:0]       sdat_sync_q;
  reg  [1:0]       stb_sync_q;
  reg  [1:0]       blank_sync_q;
  reg              sclk_prev_q;
  reg              sdat_prev_q;
  reg  [WIDTH-1:0] sreg_q;
  reg  [WIDTH-1:0] latch_q;
  wire             sclk_rise;
  wire             f_in_ready;
  wire             f_out_valid;
  wire             f_out_data;
  wire             shift_now;

  // data is sampled one clk before the synchronised edge, matching its own pipeline
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_sync_q  <= 2'h0;
      sdat_sync_q  <= 2'h0;
      stb_sync_q   <= 2'h0;
      blank_sync_q <= 2'h3;
      sclk_prev_q  <= 1'b0;
      sdat_prev_q  <= 1'b0;
    end else if (clk_en) begin
      sclk_sync_q  <= {sclk_sync_q[0], shift_clk};
      sdat_sync_q  <= {sdat_sync_q[0], serial_in};
      stb_sync_q   <= {stb_sync_q[0], strobe};
      blank_sync_q <= {blank_sync_q[0], blanking};
      sclk_prev_q  <= sclk_sync_q[1];
      sdat_prev_q  <= sdat_sync_q[1];
    end
  end

  assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;

  // every rising shift-clock edge queues one bit while the fifo is not full
  sld_fifo #(
    .WIDTH (`SLD_FIFO_WIDTH),
    .DEPTH (`SLD_FIFO_DEPTH),
    .AW    (`SLD_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (sclk_rise),
    .in_data   (sdat_prev_q),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (~shift_hold)
  );

  assign shift_now = f_out_valid & ~shift_hold;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sreg_q       <= `SLD_SREG_RESET;
      latch_q      <= `SLD_LATCH_RESET;
      serial_out_q <= 1'b0;
      drive_high_q <= {WIDTH{1'b0}};
      sink_on_q    <= {WIDTH{1'b1}};
      fifo_ready_q <= 1'b1;
    end else if (clk_en) begin
      fifo_ready_q <= f_in_ready;
      if (shift_now) begin
        sreg_q <= {sreg_q[WIDTH-2:0], f_out_data}; // R1 R2 R3
      end
      serial_out_q <= sreg_q[WIDTH-1]; // R4
      if (stb_sync_q[1]) begin
        latch_q <= sreg_q; // R5 R10
      end
      if (blank_sync_q[1]) begin
        drive_high_q <= {WIDTH{1'b0}}; // R7 R8
        sink_on_q    <= {WIDTH{1'b1}}; // R7
      end else begin
        drive_high_q <= latch_q; // R9
        sink_on_q    <= ~latch_q; // R9
      end
    end
  end
endmodule // sld_driver
`default_nettype wire

/* File: sld_checker.sv */
// sld_checker.sv: port assertions for sld_driver; assumes clk_en is held high
`timescale 1ns/1ps
`default_nettype none
module sld_checker #(parameter WIDTH = 32) (
  input wire logic clk, sys_rst, shift_clk, strobe, blanking, shift_hold, fifo_ready_q, serial_out_q,
  input wire logic [WIDTH-1:0] drive_high_q, sink_on_q);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_sink_inv: assert property (sink_on_q == ~drive_high_q) else $error("sink");
  a_blank_low: assert property (blanking[*5] |-> drive_high_q == '0) else $error("blank");
  a_blank_sink: assert property (blanking[*5] |-> &sink_on_q) else $error("sink on");
  a_latch_hold: assert property ((!strobe && !blanking)[*6] |-> $stable(drive_high_q)) else $error("hold");
  a_blank_keep: assert property ((!strobe && !blanking)[*7] ##1 (!strobe && blanking)[*5] ##1
    (!strobe && !blanking)[*7] |-> drive_high_q == $past(drive_high_q, 12)) else $error("keep");
  a_strobe_tap: assert property ((strobe && !blanking)[*7] |-> drive_high_q[WIDTH-1] == $past(serial_out_q))
    else $error("tap");
  a_hold_shift: assert property (shift_hold[*3] |-> $stable(serial_out_q)) else $error("shift");
  a_hold_ready: assert property ((shift_hold && !shift_clk)[*6] |-> $stable(fifo_ready_q)) else $error("ready");
endmodule // sld_checker
`default_nettype wire

/* File: sld_host.sv */
// sld_host.sv: host pin model, msb first; assumes send is called at a falling clk edge
`timescale 1ns/1ps
`default_nettype none
module sld_host (
  input wire logic clk,
  output var logic shift_clk, serial_in, strobe, blanking);
  initial {shift_clk, serial_in, strobe, blanking} = 4'h1;
  // data stands 4 clks either side of each rise, then goes to the next bit, or to its inverse after the last
  task automatic send(input logic [31:0] d, input int n);
    serial_in = d[n-1];
    for (int i = n - 1; i >= 0; i--) begin
      repeat (4) @(negedge clk);
      shift_clk = 1;
      repeat (4) @(negedge clk);
      shift_clk = 0;
      serial_in = i > 0 ? d[i-1] : ~d[0];
    end
    repeat (4) @(negedge clk);
  endtask
endmodule // sld_host
`default_nettype wire

/* File: test_serial_in_latched_driver_32.sv */
// bench top for sld_driver; assumes the host and checker files come first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin tests_run++; if ((g)!==(e)) begin bad_count++; $display("[ERR] %s exp %h got %h",n,e,g); end end
module test_serial_in_latched_driver_32;
  logic clk = 0, sys_rst = 1, clk_en = 1, shift_hold = 0;
  wire shift_clk, serial_in, strobe, blanking, fifo_ready_q, serial_out_q;
  wire [31:0] drive_high_q, sink_on_q;
  int bad_count = 0, tests_run = 0;
  localparam logic [31:0] A = 32'ha5c3_0f96;
  always #50 clk = ~clk;
  sld_host u_host (
    .clk       (clk),
    .shift_clk (shift_clk),
    .serial_in (serial_in),
    .strobe    (strobe),
    .blanking  (blanking)
  );
  sld_driver u_dut (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .clk_en       (clk_en),
    .shift_clk    (shift_clk),
    .serial_in    (serial_in),
    .strobe       (strobe),
    .blanking     (blanking),
    .shift_hold   (shift_hold),
    .fifo_ready_q (fifo_ready_q),
    .serial_out_q (serial_out_q),
    .drive_high_q (drive_high_q),
    .sink_on_q    (sink_on_q)
  );
  task automatic w(input int n); repeat (n) @(negedge clk); endtask
  task automatic close_out(input int late);
    bad_count += late;
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_frame;
    u_host.send(A, 32);
    u_host.strobe = 1;
    w(6);
    u_host.strobe = 0;
    u_host.blanking = 0;
    w(8);
    `CHK("drive", A, drive_high_q)
    `CHK("sink", ~A, sink_on_q)
    `CHK("cascade", A[31], serial_out_q)
    u_host.blanking = 1;
    w(5);
    `CHK("blanked", 32'h0, drive_high_q)
    `CHK("sinks on", 32'hffff_ffff, sink_on_q)
    u_host.blanking = 0;
    w(8);
    `CHK("kept", A, drive_high_q)
    u_host.send(~A, 32);
    `CHK("held", A, drive_high_q)
  endtask
  // fifo stalled: two of ten bits are refused
  task automatic t_fifo;
    shift_hold = 1;
    u_host.send(32'h3ff, 10);
    w(8);
    `CHK("full", 1'b0, fifo_ready_q)
    shift_hold = 0;
    u_host.strobe = 1;
    w(20);
    `CHK("follow", {~A[23:0], 8'hff}, drive_high_q)
  endtask
  initial #2000 sys_rst = 0;
  initial #300us close_out(1);
  initial begin
    w(22);
    t_frame;
    t_fifo;
    close_out(0);
  end
endmodule // test_serial_in_latched_driver_32
bind sld_driver sld_checker #(.WIDTH(WIDTH)) u_chk (.*);
`default_nettype wire
